// ===== common/sbt_pkg.sv
// Contract
// - The port behaves as a standard boundary-scan test access port that any compliant tester can drive.
// - The mode-select and data inputs read as high whenever nothing drives them.
// - At power-up the controller sits in its reset state without disturbing the memory.
// - Every test input is sampled on the rising test-clock edge.
// - Every test output except the memory controls, the serial data output included, changes only on the falling test-clock edge.
// - Exactly one data register sits between data-in and data-out, picked by the current instruction.
// - Serial data enters at the most significant bit of the selected register.
// - Data-out shows the least significant bit of the selected register.
// - The data-out driver is enabled only in some controller states, chosen by the current state.
// - Five rising edges with mode-select high force the controller into reset without disturbing the memory.
// - The instruction register is three bits wide and holds the identify instruction after power-up or reset.
// - Capture of the instruction register loads binary 01 into its two lowest bits.
// - A one-bit bypass register gives a short path from data-in to data-out under the bypass instruction.
package sbt_pkg;
  // ==========================================================
  // Sizes and codes
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int TMS_RESET_EDGES = 5;
  localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
  localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
  localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
  localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;
  localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;
  // Arbitrary identification value, bit 0 set as an identity code must have
  localparam logic [ID_W-1:0] ID_VALUE = 32'h0a5c_3001;
  localparam int BSR_LEN_DEF = 109;
  localparam int BSR_OE_BIT = 108;
  localparam logic BYP_CAPTURE = 1'h0;

  // ==========================================================
  // Controller states
  typedef enum logic [3:0] {
    ST_TLR = 4'b0000,
    ST_RTI = 4'b0001,
    ST_SEL_DR = 4'b0010,
    ST_CAP_DR = 4'b0011,
    ST_SHIFT_DR = 4'b0100,
    ST_EXIT1_DR = 4'b0101,
    ST_PAUSE_DR = 4'b0110,
    ST_EXIT2_DR = 4'b0111,
    ST_UPD_DR = 4'b1000,
    ST_SEL_IR = 4'b1001,
    ST_CAP_IR = 4'b1010,
    ST_SHIFT_IR = 4'b1011,
    ST_EXIT1_IR = 4'b1100,
    ST_PAUSE_IR = 4'b1101,
    ST_EXIT2_IR = 4'b1110,
    ST_UPD_IR = 4'b1111
  } sbt_state_t;

  // Memory-side test controls
  typedef struct packed {
    logic extest;
    logic out_hiz;
  } sbt_mem_ctl_t;
endpackage

// ===== core/sbt_tap.sv
`timescale 1ns/1ps
`default_nettype none
module sbt_tap #(
  parameter int BSR_LEN = sbt_pkg::BSR_LEN_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic tck,
  input wire logic tms_in,
  input wire logic tms_drv,
  input wire logic tdi_in,
  input wire logic tdi_drv,
  input wire logic [BSR_LEN-1:0] pin_sample,
  output logic tdo_out,
  output logic tdo_oe,
  output logic [BSR_LEN-1:0] bsr_update,
  output var sbt_pkg::sbt_mem_ctl_t mem_ctl
);
  // ==========================================================
  // Input pull-ups
  logic tms_s;
  logic tdi_s;
  assign tms_s = tms_drv ? tms_in : 1'b1;
  assign tdi_s = tdi_drv ? tdi_in : 1'b1;

  // ==========================================================
  // Controller state machine
  sbt_pkg::sbt_state_t state_r, state_nxt;

  // Next state from sampled mode-select
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sbt_pkg::ST_TLR: state_nxt = tms_s ? sbt_pkg::ST_TLR : sbt_pkg::ST_RTI;
      sbt_pkg::ST_RTI: state_nxt = tms_s ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_RTI;
      sbt_pkg::ST_SEL_DR: state_nxt = tms_s ? sbt_pkg::ST_SEL_IR : sbt_pkg::ST_CAP_DR;
      sbt_pkg::ST_CAP_DR: state_nxt = tms_s ? sbt_pkg::ST_EXIT1_DR : sbt_pkg::ST_SHIFT_DR;
      sbt_pkg::ST_SHIFT_DR: state_nxt = tms_s ? sbt_pkg::ST_EXIT1_DR : sbt_pkg::ST_SHIFT_DR;
      sbt_pkg::ST_EXIT1_DR: state_nxt = tms_s ? sbt_pkg::ST_UPD_DR : sbt_pkg::ST_PAUSE_DR;
      sbt_pkg::ST_PAUSE_DR: state_nxt = tms_s ? sbt_pkg::ST_EXIT2_DR : sbt_pkg::ST_PAUSE_DR;
      sbt_pkg::ST_EXIT2_DR: state_nxt = tms_s ? sbt_pkg::ST_UPD_DR : sbt_pkg::ST_SHIFT_DR;
      sbt_pkg::ST_UPD_DR: state_nxt = tms_s ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_RTI;
      sbt_pkg::ST_SEL_IR: state_nxt = tms_s ? sbt_pkg::ST_TLR : sbt_pkg::ST_CAP_IR;
      sbt_pkg::ST_CAP_IR: state_nxt = tms_s ? sbt_pkg::ST_EXIT1_IR : sbt_pkg::ST_SHIFT_IR;
      sbt_pkg::ST_SHIFT_IR: state_nxt = tms_s ? sbt_pkg::ST_EXIT1_IR : sbt_pkg::ST_SHIFT_IR;
      sbt_pkg::ST_EXIT1_IR: state_nxt = tms_s ? sbt_pkg::ST_UPD_IR : sbt_pkg::ST_PAUSE_IR;
      sbt_pkg::ST_PAUSE_IR: state_nxt = tms_s ? sbt_pkg::ST_EXIT2_IR : sbt_pkg::ST_PAUSE_IR;
      sbt_pkg::ST_EXIT2_IR: state_nxt = tms_s ? sbt_pkg::ST_UPD_IR : sbt_pkg::ST_SHIFT_IR;
      sbt_pkg::ST_UPD_IR: state_nxt = tms_s ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_RTI;
      default: state_nxt = sbt_pkg::ST_TLR;
    endcase
  end

  // State register, reset state at power-up
  always_ff @(posedge tck or posedge reset) begin
    if (reset) begin
      state_r <= sbt_pkg::ST_TLR;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Instruction and data registers
  logic [sbt_pkg::IR_W-1:0] ir_r, ir_nxt;
  logic [sbt_pkg::IR_W-1:0] irsh_r, irsh_nxt;
  logic byp_r, byp_nxt;
  logic [sbt_pkg::ID_W-1:0] id_r, id_nxt;
  logic [BSR_LEN-1:0] bsr_r, bsr_nxt;
  logic [BSR_LEN-1:0] upd_r, upd_nxt;
  logic sel_bsr;
  logic sel_id;
  logic [BSR_LEN-1:0] upd_init;
  logic [BSR_LEN-1:0] pin_s1_r, pin_s1_nxt;
  logic [BSR_LEN-1:0] pin_s2_r, pin_s2_nxt;

  // Pin ring passes two test-clock flops before capture
  always_comb begin
    pin_s1_nxt = pin_sample;
    pin_s2_nxt = pin_s1_r;
  end

  always_ff @(posedge tck or posedge reset) begin
    if (reset) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= pin_s1_nxt;
      pin_s2_r <= pin_s2_nxt;
    end
  end

  always_comb begin
    upd_init = '0;
    upd_init[sbt_pkg::BSR_OE_BIT] = 1'b1;
  end

  assign sel_id = (ir_r == sbt_pkg::INS_IDCODE);
  assign sel_bsr = (ir_r == sbt_pkg::INS_EXTEST) || (ir_r == sbt_pkg::INS_SAMPLE) ||
                   (ir_r == sbt_pkg::INS_SAMPLE_Z);

  // Capture and shift of every scan register, update of the instruction and boundary registers
  always_comb begin
    ir_nxt = ir_r;
    irsh_nxt = irsh_r;
    byp_nxt = byp_r;
    id_nxt = id_r;
    bsr_nxt = bsr_r;
    upd_nxt = upd_r;
    case (state_r)
      sbt_pkg::ST_TLR: begin
        ir_nxt = sbt_pkg::INS_IDCODE;
        upd_nxt = upd_init;
      end
      sbt_pkg::ST_CAP_IR: begin
        irsh_nxt = {ir_r[sbt_pkg::IR_W-1:2], sbt_pkg::IR_CAPTURE_PAT};
      end
      sbt_pkg::ST_SHIFT_IR: begin
        irsh_nxt = {tdi_s, irsh_r[sbt_pkg::IR_W-1:1]};
      end
      sbt_pkg::ST_UPD_IR: begin
        ir_nxt = irsh_r;
      end
      sbt_pkg::ST_CAP_DR: begin
        byp_nxt = sbt_pkg::BYP_CAPTURE;
        if (sel_id) begin
          id_nxt = sbt_pkg::ID_VALUE;
        end else if (sel_bsr) begin
          bsr_nxt = pin_s2_r;
        end
      end
      sbt_pkg::ST_SHIFT_DR: begin
        if (sel_id) begin
          id_nxt = {tdi_s, id_r[sbt_pkg::ID_W-1:1]};
        end else if (sel_bsr) begin
          bsr_nxt = {tdi_s, bsr_r[BSR_LEN-1:1]};
        end else begin
          byp_nxt = tdi_s;
        end
      end
      sbt_pkg::ST_UPD_DR: begin
        if (sel_bsr && (ir_r != sbt_pkg::INS_SAMPLE_Z)) begin
          upd_nxt = bsr_r;
        end
      end
      default: begin
        ir_nxt = ir_r;
      end
    endcase
  end

  // Scan registers on the rising edge
  always_ff @(posedge tck or posedge reset) begin
    if (reset) begin
      ir_r <= sbt_pkg::INS_IDCODE;
      irsh_r <= '0;
      byp_r <= 1'b0;
      id_r <= '0;
      bsr_r <= '0;
      upd_r <= '0;
      upd_r[sbt_pkg::BSR_OE_BIT] <= 1'b1;
    end else begin
      ir_r <= ir_nxt;
      irsh_r <= irsh_nxt;
      byp_r <= byp_nxt;
      id_r <= id_nxt;
      bsr_r <= bsr_nxt;
      upd_r <= upd_nxt;
    end
  end

  // ==========================================================
  // Serial output on the falling edge
  logic tdo_nxt;
  logic tdo_oe_nxt;
  logic shifting;

  always_comb begin
    shifting = (state_r == sbt_pkg::ST_SHIFT_IR) || (state_r == sbt_pkg::ST_SHIFT_DR);
    tdo_oe_nxt = shifting;
    if (state_r == sbt_pkg::ST_SHIFT_IR) begin
      tdo_nxt = irsh_r[0];
    end else if (sel_id) begin
      tdo_nxt = id_r[0];
    end else if (sel_bsr) begin
      tdo_nxt = bsr_r[0];
    end else begin
      tdo_nxt = byp_r;
    end
  end

  // Output flops on the falling edge
  always_ff @(negedge tck or posedge reset) begin
    if (reset) begin
      tdo_out <= 1'b0;
      tdo_oe <= 1'b0;
      bsr_update <= '0;
    end else begin
      tdo_out <= tdo_nxt;
      tdo_oe <= tdo_oe_nxt;
      bsr_update <= upd_r;
    end
  end

  // ==========================================================
  // Memory control crossing into the system clock
  logic ext_lvl_r, ext_lvl_nxt;
  logic hiz_lvl_r, hiz_lvl_nxt;
  sbt_pkg::sbt_mem_ctl_t sync1_r, sync1_nxt, mem_nxt;

  // Levels formed on the test clock
  always_comb begin
    ext_lvl_nxt = (ir_r == sbt_pkg::INS_EXTEST);
    hiz_lvl_nxt = (ir_r == sbt_pkg::INS_SAMPLE_Z) ||
                  ((ir_r == sbt_pkg::INS_EXTEST) && !upd_r[sbt_pkg::BSR_OE_BIT]);
  end

  always_ff @(negedge tck or posedge reset) begin
    if (reset) begin
      ext_lvl_r <= 1'b0;
      hiz_lvl_r <= 1'b0;
    end else begin
      ext_lvl_r <= ext_lvl_nxt;
      hiz_lvl_r <= hiz_lvl_nxt;
    end
  end

  // Two-flop synchroniser
  always_comb begin
    sync1_nxt.extest = ext_lvl_r;
    sync1_nxt.out_hiz = hiz_lvl_r;
    mem_nxt = sync1_r;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_r <= '0;
      mem_ctl <= '0;
    end else begin
      sync1_r <= sync1_nxt;
      mem_ctl <= mem_nxt;
    end
  end

  // ==========================================================
  // Checks on the test clock
  sequence s_tms_high5;
    tms_s [*5];
  endsequence

  AST_TMS5_RESET: assert property (@(posedge tck) disable iff (reset)
    s_tms_high5 |=> state_r == sbt_pkg::ST_TLR)
    else $error("five high mode-select edges did not reach reset");
  AST_IR_RESET: assert property (@(posedge tck) disable iff (reset)
    state_r == sbt_pkg::ST_TLR |=> ir_r == sbt_pkg::INS_IDCODE)
    else $error("instruction not identify after reset state");
  AST_CAPIR: assert property (@(posedge tck) disable iff (reset)
    state_r == sbt_pkg::ST_CAP_IR |=> irsh_r[1:0] == sbt_pkg::IR_CAPTURE_PAT)
    else $error("instruction capture pattern wrong");
  AST_TDO_OE: assert property (@(posedge tck) disable iff (reset)
    tdo_oe == ((state_r == sbt_pkg::ST_SHIFT_IR) || (state_r == sbt_pkg::ST_SHIFT_DR)))
    else $error("data-out enable outside shift states");
  AST_BYP_TDO: assert property (@(posedge tck) disable iff (reset)
    (state_r == sbt_pkg::ST_SHIFT_DR) && (ir_r == sbt_pkg::INS_BYPASS) |-> tdo_out == byp_r)
    else $error("data-out does not show bypass bit");
  AST_TDI_MSB: assert property (@(posedge tck) disable iff (reset)
    state_r == sbt_pkg::ST_SHIFT_IR |=> irsh_r[sbt_pkg::IR_W-1] == $past(tdi_s))
    else $error("data-in not shifted into msb");
  AST_BYP_CAP: assert property (@(posedge tck) disable iff (reset)
    state_r == sbt_pkg::ST_CAP_DR |=> byp_r == sbt_pkg::BYP_CAPTURE)
    else $error("bypass bit not cleared on capture");
  AST_ID_CAP: assert property (@(posedge tck) disable iff (reset)
    (state_r == sbt_pkg::ST_CAP_DR) && sel_id |=> id_r == sbt_pkg::ID_VALUE)
    else $error("identity not captured");
  AST_UPDIR: assert property (@(posedge tck) disable iff (reset)
    state_r == sbt_pkg::ST_UPD_IR |=> ir_r == $past(irsh_r))
    else $error("instruction not updated");
  // Output levels kept at each rise, compared at the following fall
  logic [1:0] out_rise_r, out_rise_nxt;
  always_comb begin
    out_rise_nxt = {tdo_out, tdo_oe};
  end
  always_ff @(posedge tck or posedge reset) begin
    if (reset) begin
      out_rise_r <= '0;
    end else begin
      out_rise_r <= out_rise_nxt;
    end
  end
  AST_FALL_EDGE: assert property (@(negedge tck) disable iff (reset)
    {tdo_out, tdo_oe} == out_rise_r)
    else $error("test outputs moved on rising edge");
endmodule
`default_nettype wire

// ===== testbench/sbt_tester.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Tester model: owns the test clock and serial lines
module sbt_tester (
  output logic tck,
  output logic tms_in,
  output logic tms_drv,
  output logic tdi_in,
  output logic tdi_drv,
  input wire logic tdo_out,
  input wire logic tdo_oe
);
  // Test clock stands low between frames
  initial begin
    tck = 1'h0;
    tms_in = 1'h1;
    tms_drv = 1'h1;
    tdi_in = 1'h0;
    tdi_drv = 1'h1;
  end
  // One test-clock cycle; outputs read just before the rise
  task automatic step(input logic m, input logic d, output logic o, output logic e);
    tms_in = tms_drv ? m : ~tms_in;
    tdi_in = tdi_drv ? d : ~tdi_in;
    #62.5;
    o = tdo_out;
    e = tdo_oe;
    tck = 1'h1;
    #62.5;
    tck = 1'h0;
  endtask
  // Idle to shift state, n bits, back through update to idle
  task automatic shift(input logic ir, input int n, input logic [108:0] din,
    output logic [108:0] dout, output logic ok);
    logic o;
    logic e;
    dout = '0;
    ok = 1'h1;
    step(1'h1, 1'h0, o, e);
    if (ir) step(1'h1, 1'h0, o, e);
    step(1'h0, 1'h0, o, e);
    step(1'h0, 1'h0, o, e);
    ok &= !e;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], dout[i], e);
      ok &= e;
    end
    step(1'h1, 1'h0, o, e);
    ok &= !e;
    step(1'h0, 1'h0, o, e);
  endtask
  // Let data-in fall back to its pull-up, or drive it again
  task automatic tdi_release(input logic rel);
    tdi_drv = !rel;
  endtask
  // Five rises with select released to its pull-up
  task automatic reset5();
    logic o;
    logic e;
    tms_drv = 1'h0;
    repeat (5) step(1'h1, 1'h0, o, e);
    tms_drv = 1'h1;
    step(1'h0, 1'h0, o, e);
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Top-level bench
module tb;
  logic clk;
  logic reset;
  logic [108:0] pin_sample;
  logic tck, tms_in, tms_drv, tdi_in, tdi_drv, tdo_out, tdo_oe;
  logic [108:0] bsr_update;
  sbt_pkg::sbt_mem_ctl_t mem_ctl;
  logic [108:0] d;
  logic ok;
  int n_mismatch = 0;
  int checked = 0;
  sbt_tap #(.BSR_LEN(109)) DUT (.clk(clk), .reset(reset), .tck(tck), .tms_in(tms_in),
    .tms_drv(tms_drv), .tdi_in(tdi_in), .tdi_drv(tdi_drv), .pin_sample(pin_sample),
    .tdo_out(tdo_out), .tdo_oe(tdo_oe), .bsr_update(bsr_update), .mem_ctl(mem_ctl));
  sbt_tester u_tst (.tck(tck), .tms_in(tms_in), .tms_drv(tms_drv), .tdi_in(tdi_in),
    .tdi_drv(tdi_drv), .tdo_out(tdo_out), .tdo_oe(tdo_oe));
  // System clock
  always #25 clk = ~clk;
  // Compare and count
  task automatic chk(input logic [108:0] got, input logic [108:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic test_done();
    $display("mismatches=%0d checks=%0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Identify register read, LSB first
  task automatic t_id();
    u_tst.shift(1'h0, 32, '0, d, ok);
    chk(d, 109'(sbt_pkg::ID_VALUE));
    chk(ok, 1'h1);
    chk(mem_ctl, '0);
  endtask
  // Instruction load returns the capture pattern
  task automatic t_ir(input logic [2:0] ins, input logic [2:0] cap);
    u_tst.shift(1'h1, 3, 109'(ins), d, ok);
    chk(d, 109'(cap));
    chk(ok, 1'h1);
  endtask
  // Bypass gives one-bit delay led by a captured zero
  task automatic t_byp();
    t_ir(sbt_pkg::INS_BYPASS, 3'h1);
    u_tst.shift(1'h0, 8, 109'h5a, d, ok);
    chk(d, 109'hb4);
    u_tst.tdi_release(1'h1);
    u_tst.shift(1'h0, 8, '0, d, ok);
    u_tst.tdi_release(1'h0);
    chk(d, 109'hfe);
  endtask
  // Sample the ring, preload output bit low, then enter the pin tests
  task automatic t_bsr();
    @(posedge clk) pin_sample <= 109'h1_dead_beef_0123_4567;
    t_ir(sbt_pkg::INS_SAMPLE, 3'h1);
    u_tst.shift(1'h0, 109, 109'h0ff0_1234, d, ok);
    chk(d, 109'h1_dead_beef_0123_4567);
    repeat (2) @(posedge clk);
    chk(bsr_update, 109'h0ff0_1234);
    t_ir(sbt_pkg::INS_EXTEST, 3'h5);
    repeat (4) @(posedge clk);
    chk(mem_ctl, 2'h3);
    t_ir(sbt_pkg::INS_SAMPLE_Z, 3'h1);
    repeat (4) @(posedge clk);
    chk(mem_ctl, 2'h1);
  endtask
  // Main sequence
  initial begin
    clk = 1'h0;
    reset = 1'h1;
    pin_sample = '0;
    repeat (8) @(posedge clk);
    chk(tdo_oe, 1'h0);
    reset <= 1'h0;
    u_tst.reset5();
    t_id();
    t_byp();
    u_tst.reset5();
    t_id();
    t_bsr();
    test_done();
  end
  // Hang guard
  initial begin
    #1ms;
    n_mismatch++;
    test_done();
  end
endmodule
`default_nettype wire
